//--- shared/apes_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef APES_MAP_SVH
`define APES_MAP_SVH
// Byte addresses on the APB bus
`define APES_PEC_OFF 12'h000
`define APES_DTC_OFF 12'h004
`define APES_TBP_OFF 12'h008
`define APES_TAL_OFF 12'h00c
`define APES_STS_OFF 12'h010
// Enable register field positions
`define APES_PDEN_BIT 7
`define APES_SDEN_BIT 6
`define APES_PDBY_BIT 5
`define APES_SDBY_BIT 4
`define APES_RSV_BIT 3
`define APES_PUEN_BIT 2
`define APES_STP_BIT 1
`define APES_STS_BIT 0
// Dead-time control fields
`define APES_DT_PRI_LSB 0
`define APES_DT_SEC_LSB 4
`define APES_DT_DESATURATION_COMPARATOR_COMP_OUT_ENABLE_BIT 8
// Reset values and enable register write mask
`define APES_PEC_RST 8'h00
`define APES_DTC_RST 9'h000
`define APES_TBP_RST 8'hff
`define APES_TAL_RST 8'h00
`define APES_PEC_MASK 8'hf7
// Dead time step and clock period in ns
`define APES_DT_STEP_NS 16
`define APES_DT_MAX_NS 256
`define APES_CLK_NS 4
`define APES_DT_STEP_CYC (`APES_DT_STEP_NS / `APES_CLK_NS)
`endif

//--- shared/apes_pkg.sv
// Types shared by the enable and steering block
package apes_pkg;
  typedef enum logic [2:0] {
    APES_ST_OFF = 3'b001,
    APES_ST_PRI = 3'b010,
    APES_ST_SEC = 3'b100
  } apes_steer_e;
endpackage

//--- design/apes_pwm.sv
// Open-loop steering PWM generator: period and duty from timer values
module apes_pwm
  import apes_pkg::*;
#(
  parameter int W = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [W-1:0] period,
  input wire logic [W-1:0] duty,
  output logic pwm
);
  logic [W-1:0] cnt_q;
  // Counter wrapping at period, held at zero while run is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (!run || cnt_q >= period)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end
  // High while count below duty
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm <= 1'b0;
    else
      pwm <= run && (cnt_q < duty);
  end
endmodule // apes_pwm

//--- design/apes_dtdly.sv
// Rising-edge dead-time delay with bypass for one gate driver
`include "apes_map.svh"
module apes_dtdly
  import apes_pkg::*;
#(
  parameter int CW = 8
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  input wire logic [3:0] code,
  input wire logic bypass,
  output logic dout
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] lim;
  // Code n gives (n+1) steps of 16 ns
  assign lim = CW'((32'(code) + 1) * `APES_DT_STEP_CYC);
  // Count cycles the input has been high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (!din)
      cnt_q <= '0;
    else if (cnt_q < lim)
      cnt_q <= cnt_q + 1'b1;
  end
  // Turn-on delayed, turn-off immediate
  always_comb
  begin
    dout = din && (bypass || cnt_q >= lim);
  end
endmodule // apes_dtdly

//--- design/apes_top.sv
// Analog peripheral enable register and gate-drive steering logic
`include "apes_map.svh"
module apes_top
  import apes_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic loop_primary,
  input wire logic loop_secondary,
  input wire logic ovp_active,
  output logic primary_gate_out,
  output logic secondary_gate_out,
  output logic sense_pullup_on,
  output logic desaturation_comparator_comp_out_enable
);
  logic [7:0] pec_q;
  logic [8:0] dtc_q;
  logic [7:0] tbp_q;
  logic [7:0] tal_q;
  logic ovp_s1_q;
  logic ovp_s2_q;
  logic wr;
  logic hit;
  logic steer_run;
  logic pwm;
  logic pri_raw;
  logic sec_raw;
  logic pri_dt;
  logic sec_dt;
  apes_steer_e mode;

  // Address decode shared by read and write paths
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `APES_PEC_OFF) || (a == `APES_DTC_OFF) ||
             (a == `APES_TBP_OFF) || (a == `APES_TAL_OFF) ||
             (a == `APES_STS_OFF);
  endfunction

  // Zero-wait slave; unmapped address answers with error
  assign pready = 1'b1;
  assign hit = mapped(paddr);
  assign pslverr = psel && penable && !hit;
  assign wr = psel && penable && pwrite && hit;

  // Enable register, bit 3 unimplemented
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pec_q <= `APES_PEC_RST;
    else if (wr && paddr == `APES_PEC_OFF)
      pec_q <= pwdata[7:0] & `APES_PEC_MASK;
  end

  // Dead-time control, desaturation_comparator output enable included
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dtc_q <= `APES_DTC_RST;
    else if (wr && paddr == `APES_DTC_OFF)
      dtc_q <= pwdata[8:0];
  end

  // Timer B period and timer A count low images
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tbp_q <= `APES_TBP_RST;
      tal_q <= `APES_TAL_RST;
    end
    else if (wr && paddr == `APES_TBP_OFF)
      tbp_q <= pwdata[7:0];
    else if (wr && paddr == `APES_TAL_OFF)
      tal_q <= pwdata[7:0];
  end

  // Overvoltage flag synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovp_s1_q <= 1'b0;
      ovp_s2_q <= 1'b0;
    end
    else
    begin
      ovp_s1_q <= ovp_active;
      ovp_s2_q <= ovp_s1_q;
    end
  end

  // Read mux, registered data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        `APES_PEC_OFF: prdata <= {24'h0, pec_q};
        `APES_DTC_OFF: prdata <= {23'h0, dtc_q};
        `APES_TBP_OFF: prdata <= {24'h0, tbp_q};
        `APES_TAL_OFF: prdata <= {24'h0, tal_q};
        `APES_STS_OFF: prdata <= {24'h0, primary_gate_out,
          secondary_gate_out, ovp_s2_q, 2'h0, mode};
        default: prdata <= '0;
      endcase
    end
  end

  // Steering mode select, primary dominant
  always_comb
  begin
    if (pec_q[`APES_STP_BIT])
      mode = APES_ST_PRI;
    else if (pec_q[`APES_STS_BIT] && ovp_s2_q)
      mode = APES_ST_SEC;
    else
      mode = APES_ST_OFF;
  end

  assign steer_run = (mode != APES_ST_OFF);

  apes_pwm #(.W(8)) u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .run(steer_run),
    .period(tbp_q),
    .duty(tal_q),
    .pwm(pwm)
  );

  // Steering replaces loop drive on the chosen driver and holds the other driver low
  always_comb
  begin
    pri_raw = loop_primary;
    sec_raw = loop_secondary;
    unique case (mode)
      APES_ST_PRI:
      begin
        pri_raw = pwm;
        sec_raw = 1'b0;
      end
      APES_ST_SEC:
      begin
        pri_raw = 1'b0;
        sec_raw = pwm;
      end
      APES_ST_OFF:
      begin
        pri_raw = loop_primary;
        sec_raw = loop_secondary;
      end
    endcase
  end

  apes_dtdly u_dt_pri (
    .pclk(pclk),
    .presetn(presetn),
    .din(pri_raw),
    .code(dtc_q[`APES_DT_PRI_LSB +: 4]),
    .bypass(pec_q[`APES_PDBY_BIT]),
    .dout(pri_dt)
  );

  apes_dtdly u_dt_sec (
    .pclk(pclk),
    .presetn(presetn),
    .din(sec_raw),
    .code(dtc_q[`APES_DT_SEC_LSB +: 4]),
    .bypass(pec_q[`APES_SDBY_BIT]),
    .dout(sec_dt)
  );

  // Gate outputs registered, forced low when disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_gate_out <= 1'b0;
      secondary_gate_out <= 1'b0;
    end
    else
    begin
      primary_gate_out <= pec_q[`APES_PDEN_BIT] && pri_dt;
      secondary_gate_out <= pec_q[`APES_SDEN_BIT] && sec_dt;
    end
  end

  // Pull-up and desaturation_comparator enable follow their bits
  assign sense_pullup_on = pec_q[`APES_PUEN_BIT];
  assign desaturation_comparator_comp_out_enable = dtc_q[`APES_DT_DESATURATION_COMPARATOR_COMP_OUT_ENABLE_BIT];

  // Disabled primary never drives high
  chk_pri_disabled_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pec_q[`APES_PDEN_BIT] |=> !primary_gate_out)
    else $error("primary output high while disabled");

  chk_sec_disabled_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pec_q[`APES_SDEN_BIT] |=> !secondary_gate_out)
    else $error("secondary output high while disabled");

  chk_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pec_q[`APES_RSV_BIT] == 1'b0)
    else $error("reserved bit set");

  chk_pullup_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == `APES_PEC_OFF)
      |=> sense_pullup_on == $past(pwdata[`APES_PUEN_BIT]))
    else $error("pull-up not applied");

  chk_primary_dominant: assert property (
    @(posedge pclk) disable iff (!presetn)
    pec_q[`APES_STP_BIT] |=> !secondary_gate_out || $past(mode) != APES_ST_PRI)
    else $error("secondary pulsed under primary steering");

  chk_sec_needs_ovp: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == APES_ST_SEC) |-> ovp_s2_q && !pec_q[`APES_STP_BIT])
    else $error("secondary steering without overvoltage");

  chk_steer_pri_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode == APES_ST_PRI) [*2] |=> !secondary_gate_out)
    else $error("secondary active in primary steering");

  chk_bypass_immediate: assert property (
    @(posedge pclk) disable iff (!presetn)
    pec_q[`APES_PDBY_BIT] && pec_q[`APES_PDEN_BIT] && pri_raw
      |=> primary_gate_out)
    else $error("bypass did not remove dead time");

  chk_deadtime_delay: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pec_q[`APES_PDBY_BIT] && $rose(pri_raw) |=> !primary_gate_out)
    else $error("primary turned on without dead time");
endmodule // apes_top

//--- bench/test_analog_periph_enable_steering.sv
// Self-checking bench for the enable register and steering block
`include "apes_map.svh"
module test_analog_periph_enable_steering;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pri_out, sec_out, pu_on, ds_en;
  logic loop_p = 0, loop_s = 0, ovp = 0;
  int n_mismatch = 0, n_checks = 0;
  // Reference register images and writable masks
  logic [31:0] mdl [4] = '{32'h0, 32'h0, 32'hff, 32'h0};
  logic [31:0] msk [4] = '{32'hf7, 32'h1ff, 32'hff, 32'hff};
  // Enable words for the four steering cases
  logic [7:0] pec_modes [4] = '{8'hf2, 8'hf1, 8'hf1, 8'hf3};

  // 250 MHz clock
  always #2 pclk = ~pclk;

  apes_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .loop_primary(loop_p), .loop_secondary(loop_s), .ovp_active(ovp),
    .primary_gate_out(pri_out), .secondary_gate_out(sec_out),
    .sense_pullup_on(pu_on), .desaturation_comparator_comp_out_enable(ds_en));

  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  // Register write, model follows
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
    if (a < 12'h010)
      mdl[a[3:2]] = d & msk[a[3:2]];
  endtask

  // Expected status word while gate outputs idle
  function automatic logic [31:0] sts_exp();
    logic [2:0] m;
    if (mdl[0][`APES_STP_BIT])
      m = apes_pkg::APES_ST_PRI;
    else if (mdl[0][`APES_STS_BIT] && ovp)
      m = apes_pkg::APES_ST_SEC;
    else
      m = apes_pkg::APES_ST_OFF;
    sts_exp = {26'h0, ovp, 2'h0, m};
  endfunction

  // Register read compared with the model
  task automatic rd(input logic [11:0] a);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    if (a == `APES_STS_OFF)
      chk(r, sts_exp());
    else
      chk(r, a < `APES_STS_OFF ? mdl[a[3:2]] : 32'h0);
    chk({31'h0, e}, {31'h0, a > 12'h010});
  endtask

  // Turn-on latency of one gate output in cycles
  task automatic lat(input int s, output int n);
    if (s)
      loop_s <= 1;
    else
      loop_p <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((s ? sec_out : pri_out) !== 1'b1 && n < 200);
    if ((s ? sec_out : pri_out) !== 1'b1)
    begin
      n_mismatch++;
      give_verdict();
    end
    loop_p <= 0;
    loop_s <= 0;
    repeat (4) @(posedge pclk);
  endtask

  // Count high cycles on both gate outputs after settling
  task automatic cnt(input int c, output int hp, output int hs);
    hp = 0;
    hs = 0;
    repeat (4) @(posedge pclk);
    repeat (c)
    begin
      @(posedge pclk);
      hp += (pri_out === 1'b1);
      hs += (sec_out === 1'b1);
    end
  endtask

  // Main sequence
  initial
  begin
    int p, d, a, b, c, e, hp, hs;
    void'($urandom(76));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++) rd(12'(i * 4));
    wr(`APES_PEC_OFF, 32'hffff_ffff);
    rd(`APES_PEC_OFF);
    for (int i = 0; i < 8; i++)
    begin
      wr(12'(($urandom % 5) * 4), $urandom);
      rd(12'h014);
      for (int j = 0; j < 4; j++) rd(12'(j * 4));
      chk({31'h0, pu_on}, {31'h0, mdl[0][2]});
      chk({31'h0, ds_en}, {31'h0, mdl[1][8]});
    end
    $display("test registers done");
    wr(`APES_PEC_OFF, 32'h00);
    loop_p <= 1;
    loop_s <= 1;
    cnt(20, hp, hs);
    chk(hp + hs, 0);
    wr(`APES_PEC_OFF, 32'hb0);
    cnt(20, hp, hs);
    chk(hp, 20);
    chk(hs, 0);
    wr(`APES_PEC_OFF, 32'h70);
    cnt(20, hp, hs);
    chk(hp, 0);
    chk(hs, 20);
    loop_p <= 0;
    loop_s <= 0;
    $display("test enables done");
    wr(`APES_DTC_OFF, 32'h000);
    wr(`APES_PEC_OFF, 32'hc0);
    lat(0, a);
    wr(`APES_DTC_OFF, 32'h00f);
    lat(0, b);
    chk(b - a, 60);
    lat(1, c);
    chk(c, a);
    wr(`APES_PEC_OFF, 32'he0);
    lat(0, e);
    chk({31'h0, e < a}, 32'h1);
    wr(`APES_PEC_OFF, 32'hd0);
    lat(0, c);
    chk(c, b);
    lat(1, c);
    chk(c, e);
    $display("test dead time done");
    p = 8 + $urandom % 32;
    d = 1 + $urandom % p;
    wr(`APES_TBP_OFF, 32'(p));
    wr(`APES_TAL_OFF, 32'(d));
    chk({31'h0, ds_en}, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      ovp <= (k >= 2);
      loop_s <= (k == 0);
      wr(`APES_PEC_OFF, {24'h0, pec_modes[k]});
      repeat (2 * (p + 1)) @(posedge pclk);
      cnt(4 * (p + 1), hp, hs);
      chk(hp, (k == 0 || k == 3) ? 4 * d : 0);
      chk(hs, (k == 2) ? 4 * d : 0);
    end
    $display("test steering done");
    give_verdict();
  end
endmodule // test_analog_periph_enable_steering
